/* File: rtl/spcs_ctrl.v */
// control, status and interrupt logic of the serial port, apb slave
// assumes a shift engine that reports busy, done and the received byte
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "spcs_map.vh"
module spcs_ctrl (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire xfer_busy,
   input wire xfer_done,
   input wire [7:0] rx_byte,
   input wire ss_pin,
   input wire cpu_irq_mask,
   output reg tx_load,
   output reg [7:0] tx_byte,
   output reg irq,
   output reg wake_wait,
   output reg wake_halt,
   output reg sck_o,
   output reg sck_oe,
   output reg mosi_oe,
   output reg miso_oe,
   output reg ss_gpio_free,
   output reg pins_alt,
   output reg controller_mode,
   output reg capture_phase,
   output reg idle_level,
   output reg target_selected_n
);
   reg [7:0] ctrl_q;
   reg done_q, write_collision_flag_q, ovr_q, fault_q;
   reg [2:0] csr_sw_q;
   reg [7:0] rxbuf_q;
   reg done_arm_q, write_collision_flag_arm_q, fault_arm_q;
   reg ss_s1_q, ss_s2_q, ss_s3_q, ss_pin_q;
   reg sck_q;
   wire setup, acc;
   wire [7:0] idx;
   wire hit_data, hit_ctrl, hit_csr, mapped;
   wire wr_ctrl, wr_csr, wr_data, rd_csr, rd_data;
   wire ss_int, fault_ev, data_ok, tick, run;
   wire [7:0] csr_val;
   wire [7:0] ctrl_wr;
   wire [7:0] csr_wr;

   assign setup = psel & ~penable;
   assign acc = psel & penable & pready;
   assign idx = paddr[`SPCS_AW-1:2];
   assign hit_data = (idx == `SPCS_IDX_DATA) & (paddr[1:0] == 2'h0);
   assign hit_ctrl = (idx == `SPCS_IDX_CTRL) & (paddr[1:0] == 2'h0);
   assign hit_csr = (idx == `SPCS_IDX_CSR) & (paddr[1:0] == 2'h0);
   assign mapped = (paddr[31:`SPCS_AW] == 22'h000000) & (hit_data | hit_ctrl | hit_csr);
   assign wr_ctrl = acc & pwrite & mapped & hit_ctrl;
   assign wr_csr = acc & pwrite & mapped & hit_csr;
   assign wr_data = acc & pwrite & mapped & hit_data;
   assign rd_csr = acc & ~pwrite & mapped & hit_csr;
   assign rd_data = acc & ~pwrite & mapped & hit_data;

   // reserved bit reads zero; flags occupy the top nibble
   assign csr_val = {done_q, write_collision_flag_q, ovr_q, fault_q, 1'b0, csr_sw_q};
   // only the software bits of a status write are kept
   assign csr_wr = pwdata[7:0] & `SPCS_CSR_WMASK;

   // pin select passes three flops; a change counts once two agree
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ss_s1_q <= 1'b1;
         ss_s2_q <= 1'b1;
         ss_s3_q <= 1'b1;
         ss_pin_q <= 1'b1;
      end else begin
         ss_s1_q <= ss_pin;
         ss_s2_q <= ss_s1_q;
         ss_s3_q <= ss_s2_q;
         if (ss_s2_q == ss_s3_q)
            ss_pin_q <= ss_s3_q;
      end
   end

   assign ss_int = csr_sw_q[`SPCS_B_SSM] ? csr_sw_q[`SPCS_B_SSI] : ss_pin_q;
   assign fault_ev = ctrl_q[`SPCS_B_CTL] & ~ss_int;

   // data writes blocked while done is pending and status not yet read
   assign data_ok = ~done_q | done_arm_q;

   // while a fault stands, enable and controller bits cannot be set,
   // except by the control write that completes the clearing sequence
   assign ctrl_wr = (fault_q & ~fault_arm_q) ?
      (pwdata[7:0] & ~(8'h01 << `SPCS_B_PE) & ~(8'h01 << `SPCS_B_CTL)) :
      pwdata[7:0];

   // apb: no wait states, answer registered
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         if (setup & ~pwrite & mapped) begin
            if (hit_ctrl)
               prdata <= {24'h000000, ctrl_q};
            else if (hit_csr)
               prdata <= {24'h000000, csr_val};
            else
               prdata <= {24'h000000, rxbuf_q};
         end else if (setup) begin
            prdata <= 32'h00000000;
         end
      end
   end

   // control register
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `SPCS_CTRL_RST;
      end else begin
         if (wr_ctrl)
            ctrl_q <= ctrl_wr;
         if (fault_ev) begin
            ctrl_q[`SPCS_B_PE] <= 1'b0;
            ctrl_q[`SPCS_B_CTL] <= 1'b0;
         end
      end
   end

   // status flags and their clearing sequences; a set wins over a clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_q <= 1'b0;
         write_collision_flag_q <= 1'b0;
         ovr_q <= 1'b0;
         fault_q <= 1'b0;
         csr_sw_q <= 3'h0;
         done_arm_q <= 1'b0;
         write_collision_flag_arm_q <= 1'b0;
         fault_arm_q <= 1'b0;
      end else begin
         if (wr_csr)
            csr_sw_q <= csr_wr[2:0];
         // done: status read then data read or write
         if (rd_csr & done_q)
            done_arm_q <= 1'b1;
         else if ((rd_data | wr_data) & done_arm_q)
            done_arm_q <= 1'b0;
         if (xfer_done)
            done_q <= 1'b1;
         else if ((rd_data | wr_data) & done_arm_q)
            done_q <= 1'b0;
         // collision: status read then data read only
         if (rd_csr & write_collision_flag_q)
            write_collision_flag_arm_q <= 1'b1;
         else if (rd_data & write_collision_flag_arm_q)
            write_collision_flag_arm_q <= 1'b0;
         if (wr_data & xfer_busy)
            write_collision_flag_q <= 1'b1;
         else if (rd_data & write_collision_flag_arm_q)
            write_collision_flag_q <= 1'b0;
         // overrun: new byte while done still pending
         if (xfer_done & done_q)
            ovr_q <= 1'b1;
         else if (rd_csr)
            ovr_q <= 1'b0;
         // fault: status read while set, then control write
         if (rd_csr & fault_q)
            fault_arm_q <= 1'b1;
         else if (wr_ctrl)
            fault_arm_q <= 1'b0;
         if (fault_ev)
            fault_q <= 1'b1;
         else if (wr_ctrl & fault_arm_q)
            fault_q <= 1'b0;
      end
   end

   // receive buffer keeps the first byte after done was cleared
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         rxbuf_q <= 8'h00;
      else if (xfer_done & ~done_q)
         rxbuf_q <= rx_byte;
   end

   // transmit load; colliding or inhibited writes are dropped
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_load <= 1'b0;
         tx_byte <= 8'h00;
      end else begin
         tx_load <= wr_data & ~xfer_busy & data_ok;
         if (wr_data & ~xfer_busy & data_ok)
            tx_byte <= pwdata[7:0];
      end
   end

   // controller-mode clock: toggles on each half period while busy
   assign run = ctrl_q[`SPCS_B_CTL] & ctrl_q[`SPCS_B_PE] & xfer_busy;

   spcs_clkdiv u_div (
      .pclk(pclk),
      .presetn(presetn),
      .run(run),
      .sel({ctrl_q[`SPCS_B_DHI], ctrl_q[1:0]}),
      .tick(tick)
   );

   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sck_q <= 1'b0;
      else if (!run)
         sck_q <= ctrl_q[`SPCS_B_IDLE];
      else if (tick)
         sck_q <= ~sck_q;
   end

   // pin roles and interrupt / wake requests
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
         wake_wait <= 1'b0;
         wake_halt <= 1'b0;
         sck_o <= 1'b0;
         sck_oe <= 1'b0;
         mosi_oe <= 1'b0;
         miso_oe <= 1'b0;
         ss_gpio_free <= 1'b0;
         pins_alt <= 1'b0;
         controller_mode <= 1'b0;
         capture_phase <= 1'b0;
         idle_level <= 1'b0;
         target_selected_n <= 1'b1;
      end else begin
         irq <= ctrl_q[`SPCS_B_IE] & ~cpu_irq_mask &
            (done_q | fault_q | ovr_q);
         wake_wait <= ctrl_q[`SPCS_B_IE] & (done_q | fault_q | ovr_q);
         wake_halt <= ctrl_q[`SPCS_B_IE] & done_q;
         sck_o <= sck_q;
         sck_oe <= ctrl_q[`SPCS_B_PE] & ctrl_q[`SPCS_B_CTL];
         mosi_oe <= ctrl_q[`SPCS_B_PE] & ctrl_q[`SPCS_B_CTL] &
            ~csr_sw_q[`SPCS_B_ODIS];
         miso_oe <= ctrl_q[`SPCS_B_PE] & ~ctrl_q[`SPCS_B_CTL] & ~ss_int &
            ~csr_sw_q[`SPCS_B_ODIS];
         ss_gpio_free <= csr_sw_q[`SPCS_B_SSM];
         pins_alt <= ctrl_q[`SPCS_B_PE];
         controller_mode <= ctrl_q[`SPCS_B_CTL];
         capture_phase <= ctrl_q[`SPCS_B_PHASE];
         idle_level <= ctrl_q[`SPCS_B_IDLE];
         target_selected_n <= ss_int;
      end
   end
endmodule

/* File: common/spcs_map.vh */
// register map, field positions and constants of the serial port control block
// assumes a 32-bit apb bus, word-aligned registers
`ifndef SPCS_MAP_VH
`define SPCS_MAP_VH
`define SPCS_IDX_DATA 8'h21
`define SPCS_IDX_CTRL 8'h22
`define SPCS_IDX_CSR 8'h23
`define SPCS_AW 10
`define SPCS_CTRL_RST 8'h00
`define SPCS_CSR_RST 8'h00
`define SPCS_B_IE 7
`define SPCS_B_PE 6
`define SPCS_B_DHI 5
`define SPCS_B_CTL 4
`define SPCS_B_IDLE 3
`define SPCS_B_PHASE 2
`define SPCS_B_DONE 7
`define SPCS_B_WRITE_COLLISION_FLAG 6
`define SPCS_B_OVR 5
`define SPCS_B_FAULT 4
`define SPCS_B_ODIS 2
`define SPCS_B_SSM 1
`define SPCS_B_SSI 0
`define SPCS_CSR_WMASK 8'h07
`define SPCS_HALF_4 7'h01
`define SPCS_HALF_8 7'h03
`define SPCS_HALF_16 7'h07
`define SPCS_HALF_32 7'h0f
`define SPCS_HALF_64 7'h1f
`define SPCS_HALF_128 7'h3f
`endif

/* File: rtl/spcs_clkdiv.v */
// sck half-period enable generator for controller mode
// assumes sel is stable while run is high
`timescale 1ns/1ps
`include "spcs_map.vh"
module spcs_clkdiv (
   input wire pclk,
   input wire presetn,
   input wire run,
   input wire [2:0] sel,
   output reg tick
);
   reg [6:0] cnt_q;
   wire [6:0] half;

   // pattern {high bit, field} to half period minus one
   function [6:0] half_of;
      input [2:0] s;
      begin
         case (s)
            3'h4: half_of = `SPCS_HALF_4;
            3'h0: half_of = `SPCS_HALF_8;
            3'h1: half_of = `SPCS_HALF_16;
            3'h6: half_of = `SPCS_HALF_32;
            3'h2: half_of = `SPCS_HALF_64;
            3'h3: half_of = `SPCS_HALF_128;
            default: half_of = `SPCS_HALF_128;
         endcase
      end
   endfunction

   assign half = half_of(sel);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 7'h00;
         tick <= 1'b0;
      end else if (!run) begin
         cnt_q <= 7'h00;
         tick <= 1'b0;
      end else if (cnt_q >= half) begin
         cnt_q <= 7'h00;
         tick <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 7'h01;
         tick <= 1'b0;
      end
   end
endmodule

/* File: dv/spcs_far.sv */
// far-side model: shift engine with a remote spi device behind it
// assumes one byte per tx_load or push, reply is the inverted sent byte
`timescale 1ns/1ps
module spcs_far (
   input wire pclk,
   input wire presetn,
   input wire tx_load,
   input wire [7:0] tx_byte,
   input wire push,
   input wire [8:0] len,
   output reg xfer_busy,
   output reg xfer_done,
   output reg [7:0] rx_byte
);
   reg [8:0] cnt_q;
   reg [7:0] sh_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xfer_busy <= 1'b0;
         xfer_done <= 1'b0;
         cnt_q <= 9'h000;
         sh_q <= 8'h00;
         rx_byte <= 8'h00;
      end else begin
         xfer_done <= 1'b0;
         // no byte on offer: keep the lines moving
         rx_byte <= ~rx_byte;
         // remote end set to the same idle level and phase
         if ((tx_load || push) && !xfer_busy) begin
            xfer_busy <= 1'b1;
            cnt_q <= len;
            sh_q <= ~tx_byte;
         end else if (xfer_busy && cnt_q == 9'h000) begin
            xfer_busy <= 1'b0;
            xfer_done <= 1'b1;
            rx_byte <= sh_q;
         end else if (xfer_busy) begin
            cnt_q <= cnt_q - 9'h001;
         end
      end
   end
endmodule

/* File: dv/spcs_ctrl_sva.sv */
// checker for the serial port control block, bound to spcs_ctrl
// assumes registered outputs one cycle behind the registers
`timescale 1ns/1ps
module spcs_ctrl_chk (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire pready,
   input wire pslverr,
   input wire xfer_busy,
   input wire ss_pin,
   input wire cpu_irq_mask,
   input wire tx_load,
   input wire irq,
   input wire wake_wait,
   input wire wake_halt,
   input wire sck_o,
   input wire sck_oe,
   input wire mosi_oe,
   input wire miso_oe,
   input wire pins_alt,
   input wire controller_mode,
   input wire idle_level,
   input wire target_selected_n
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_irq_gate: assert property (irq == (wake_wait && !$past(cpu_irq_mask)))
      else $error("irq disagrees with enable and mask");
   a_halt_wake: assert property (wake_halt |-> wake_wait)
      else $error("halt wake without wait wake");
   a_sck_idle: assert property (!$past(xfer_busy, 2) |-> sck_o == $past(idle_level))
      else $error("sck not at idle level");
   a_sck_drive: assert property (sck_oe |-> pins_alt && controller_mode)
      else $error("sck driven outside controller mode");
   a_data_oe: assert property ((mosi_oe |-> sck_oe) and
      (miso_oe |-> pins_alt && !controller_mode && !target_selected_n))
      else $error("data output enable wrong");
   a_ready_time: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_only: assert property (pready |-> $past(psel && !penable) && psel && penable)
      else $error("ready outside access");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("slverr without ready");
   a_fault_drop: assert property (controller_mode && !ss_pin |-> ##[1:6]
      (!controller_mode && !pins_alt))
      else $error("fault did not drop controller mode");
   a_tx_gate: assert property (tx_load |-> $past(psel && penable && pready && pwrite
      && !xfer_busy) && $past(paddr) == 32'h00000084)
      else $error("load without accepted data write");
   c_irq: cover property (irq);
   c_load: cover property (tx_load);
   c_err: cover property (pslverr);
   c_halt: cover property (wake_halt);
endmodule
bind spcs_ctrl spcs_ctrl_chk CHK (.*);

/* File: dv/spi_control_status_interrupts_bench.sv */
// self-checking bench for spcs_ctrl with the far-side model
// assumes the checker is bound separately
`timescale 1ns/1ps
module spi_control_status_interrupts_bench;
   reg pclk, presetn, psel, penable, pwrite, ss_pin, cpu_irq_mask, push, err_q, pv;
   reg [31:0] paddr, pwdata, rd, seed;
   reg [8:0] len;
   wire [31:0] prdata;
   wire pready, pslverr, xfer_busy, xfer_done, tx_load, irq, wake_wait, wake_halt, sck_o;
   wire sck_oe, mosi_oe, miso_oe, ss_gpio_free, pins_alt, controller_mode, capture_phase;
   wire idle_level, target_selected_n;
   wire [7:0] rx_byte, tx_byte;
   integer error_cnt = 0, samples_checked = 0, cyc = 0, nload = 0, i, n, m, k;
   localparam D = 32'h84, C = 32'h88, S = 32'h8c;
   spcs_ctrl DUT (.*);
   spcs_far FAR (.*);
   initial begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (tx_load) nload <= nload + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         end_sim;
      end
   end
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function [31:0] pat(input integer j);
      pat = j == 0 ? 32'h20 : j == 1 ? 32'h00 : j == 2 ? 32'h01 : j == 3 ? 32'h22 :
         j == 4 ? 32'h02 : 32'h03;
   endfunction
   task end_sim;
      begin
         $display("checks %0d errors %0d", samples_checked, error_cnt);
         if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         samples_checked = samples_checked + 1;
         if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("wrong value %s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task tick(input integer c);
      repeat (c) @(posedge pclk);
   endtask
   task apb(input w, input [31:0] a, input [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
         @(posedge pclk) penable <= 1;
         do @(posedge pclk); while (pready !== 1'b1);
         rd = prdata;
         err_q = pslverr;
         psel <= 0;
         penable <= 0;
      end
   endtask
   task rdc(input [31:0] a, input [31:0] e, input string nm);
      begin
         apb(0, a, 0);
         chk(nm, e, rd);
      end
   endtask
   task wdone;
      while (xfer_done !== 1'b1) @(posedge pclk);
   endtask
   initial begin
      presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      ss_pin = 1; cpu_irq_mask = 0; push = 0; len = 9'd8; seed = 32'h6b92e7b4;
      tick(20);
      presetn <= 1;
      rdc(C, 0, "ctrl");
      rdc(S, 0, "csr");
      apb(0, 32'h90, 0);
      chk("slverr", 1, err_q);
      for (i = 0; i < 8; i = i + 1) begin
         seed = lfsr(seed);
         apb(1, C, seed & 32'haf); // port stays off while idle level moves
         rdc(C, seed & 32'haf, "ctrl");
         chk("idle", seed[3], idle_level);
         chk("phase", seed[2], capture_phase);
      end
      apb(1, S, 32'hff);
      rdc(S, 32'h07, "csr");
      chk("gpio", 1, ss_gpio_free);
      apb(1, S, 32'h02);
      tick(2);
      chk("sel", 0, target_selected_n);
      apb(1, C, 32'h40);
      tick(2);
      chk("miso_oe", 1, miso_oe);
      apb(1, S, 32'h06);
      tick(2);
      chk("miso_oe", 0, miso_oe);
      apb(1, S, 0);
      for (i = 0; i < 6; i = i + 1) begin
         apb(1, C, 32'h50 | pat(i));
         len = 9'd300;
         apb(1, D, 8'h3c);
         n = 0; k = 0; m = 0; pv = sck_o;
         while (k < 2 && n < 600) begin
            @(posedge pclk);
            if (sck_o === 1'b1 && pv === 1'b0) begin
               k = k + 1;
               if (k == 1) m = n;
            end
            pv = sck_o;
            n = n + 1;
         end
         chk("div", 4 << i, n - 1 - m);
         wdone;
         apb(0, S, 0);
         apb(0, D, 0);
      end
      len = 9'd8;
      apb(1, C, 32'hd0);
      apb(1, D, 8'h5a);
      wdone;
      tick(2);
      chk("irq", 1, irq);
      chk("halt", 1, wake_halt);
      chk("sck_oe", 1, sck_oe);
      chk("mosi_oe", 1, mosi_oe);
      chk("miso_oe", 0, miso_oe);
      m = nload;
      apb(1, D, 8'h11);
      tick(2);
      chk("load", m, nload);
      chk("tx_byte", 32'h5a, tx_byte);
      cpu_irq_mask <= 1;
      tick(3);
      chk("irq", 0, irq);
      chk("wait", 1, wake_wait);
      cpu_irq_mask <= 0;
      rdc(S, 32'h80, "csr");
      rdc(D, 32'ha5, "data");
      rdc(S, 0, "csr");
      len = 9'd40;
      apb(1, D, 8'h01);
      tick(3);
      apb(1, D, 8'h02);
      rdc(S, 32'h40, "csr");
      chk("tx_byte", 32'h01, tx_byte);
      wdone;
      rdc(S, 32'hc0, "csr");
      apb(1, D, 8'h03);
      wdone;
      rdc(S, 32'hc0, "csr");
      rdc(D, 32'hfc, "data");
      rdc(S, 0, "csr");
      len = 9'd8;
      for (i = 0; i < 2; i = i + 1) begin
         push <= 1;
         tick(1);
         push <= 0;
         wdone;
      end
      rdc(S, 32'ha0, "csr");
      rdc(D, 32'hfc, "data");
      rdc(S, 0, "csr");
      ss_pin <= 0;
      tick(8);
      rdc(S, 32'h10, "csr");
      rdc(C, 32'h80, "ctrl");
      chk("irq", 1, irq);
      chk("halt", 0, wake_halt);
      chk("wait", 1, wake_wait);
      chk("alt", 0, pins_alt);
      chk("ctl", 0, controller_mode);
      ss_pin <= 1;
      apb(1, C, 0);
      rdc(S, 0, "csr");
      end_sim;
   end
endmodule
